// [logic/rfbc_regs.sv]
// transmit and receive bias control register bank with turnaround timer
`timescale 1ns/1ps

module rfbc_regs #(
  parameter int unsigned SHORT_CYC = rfbc_pkg::TURN_SHORT_CYC,
  parameter int unsigned LONG_CYC  = rfbc_pkg::TURN_LONG_CYC
) (
  input  wire logic                        clock_in,
  input  wire logic                        resetn_in,
  input  wire logic [rfbc_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic                        reg_write_in,
  input  wire logic                        reg_read_in,
  input  wire logic [rfbc_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                        start_transmit_command_in,
  input  wire rfbc_pkg::rfbc_gain_t        agc_step_in,
  output logic      [rfbc_pkg::DATA_W-1:0] reg_rdata_out,
  output logic                             tx_enable_out,
  output logic                             tx_waiting_out,
  output rfbc_pkg::rfbc_tx_bias_t          tx_bias_out,
  output rfbc_pkg::rfbc_rx_bias_t          rx_bias_out
);
  import rfbc_pkg::*;

  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC ||
      LONG_CYC >= (1 << TURN_CNT_W)) begin : g_bad_counts
    $error("rfbc_regs: turnaround counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [1:0] pick2(input rfbc_gain_t g,
                                       input logic [1:0] hi,
                                       input logic [1:0] md,
                                       input logic [1:0] lo);
    case (g)
      GAIN_HIGH: pick2 = hi;
      GAIN_MED:  pick2 = md;
      default:   pick2 = lo;
    endcase
  endfunction : pick2

  function automatic logic [TURN_CNT_W-1:0] turn_load(input logic sel);
    // count of cycles left after the command edge
    if (sel) begin
      turn_load = TURN_CNT_W'(LONG_CYC - 1);
    end else begin
      turn_load = TURN_CNT_W'(SHORT_CYC - 1);
    end
  endfunction : turn_load

  ////////////////////////////////////////////////////////////////////////////
  // state
  rfbc_state_t s_reg;
  rfbc_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 16'h0000;
    if (reg_write_in) begin
      case (reg_addr_in)
        TX_CTRL_ADDR:  s_next.tx_ctrl  = reg_wdata_in;
        RX_CTRL0_ADDR: s_next.rx_ctrl0 = reg_wdata_in & RX_CTRL_MASK;
        RX_CTRL1_ADDR: s_next.rx_ctrl1 = reg_wdata_in & RX_CTRL_MASK;
        default: ;
      endcase
    end
    // bit 5 is held at one whatever is written, so a careless write is safe
    s_next.tx_ctrl = s_next.tx_ctrl | TX_CTRL_FIXED1;
    if (reg_read_in) begin
      case (reg_addr_in)
        TX_CTRL_ADDR:  s_next.rdata = s_reg.tx_ctrl;
        RX_CTRL0_ADDR: s_next.rdata = s_reg.rx_ctrl0;
        RX_CTRL1_ADDR: s_next.rdata = s_reg.rx_ctrl1;
        default:       s_next.rdata = 16'h0000;
      endcase
    end
    // delay is latched at the command; a later rewrite does not stretch it
    case (s_reg.tx_state)
      TX_IDLE: begin
        if (start_transmit_command_in) begin
          s_next.tx_state = TX_WAIT;
          s_next.turn_cnt = turn_load(s_reg.tx_ctrl[TX_DELAY_BIT]);
        end
      end
      TX_WAIT: begin
        if (s_reg.turn_cnt == '0) begin
          s_next.tx_state = TX_ON;
        end else begin
          s_next.turn_cnt = s_reg.turn_cnt - 1'b1;
        end
      end
      TX_ON: begin
        if (start_transmit_command_in) begin
          s_next.tx_state = TX_WAIT;
          s_next.turn_cnt = turn_load(s_reg.tx_ctrl[TX_DELAY_BIT]);
        end
      end
      default: s_next.tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.tx_ctrl  <= TX_CTRL_RESET;
      s_reg.rx_ctrl0 <= RX_CTRL0_RESET;
      s_reg.rx_ctrl1 <= RX_CTRL1_RESET;
      s_reg.tx_state <= TX_IDLE;
      s_reg.turn_cnt <= '0;
      s_reg.rdata    <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and analog control outputs
  assign reg_rdata_out  = s_reg.rdata;
  assign tx_enable_out  = (s_reg.tx_state == TX_ON);
  assign tx_waiting_out = (s_reg.tx_state == TX_WAIT);

  always_comb begin
    tx_bias_out.tx_mixer_buffer_bias     = s_reg.tx_ctrl[15:14];
    tx_bias_out.tx_mixer_varactor_select = s_reg.tx_ctrl[12:11];
    tx_bias_out.tx_mixer_current_select  = s_reg.tx_ctrl[10:9];
    tx_bias_out.power_amp_current_adjust = s_reg.tx_ctrl[8:6];
    tx_bias_out.output_power_level       = s_reg.tx_ctrl[4:0];
  end

  always_comb begin
    rx_bias_out.rx_mixer_buffer_bias = s_reg.rx_ctrl0[13:12];
    rx_bias_out.amp_comp_current = pick2(agc_step_in,
      s_reg.rx_ctrl0[11:10], s_reg.rx_ctrl0[9:8], s_reg.rx_ctrl0[7:6]);
    rx_bias_out.amp_main_current = pick2(agc_step_in,
      s_reg.rx_ctrl0[5:4], s_reg.rx_ctrl0[3:2], s_reg.rx_ctrl0[1:0]);
    // top step has no reduced-gain bit, bottom step no boost bit
    case (agc_step_in)
      GAIN_HIGH: begin
        rx_bias_out.amp_reduced_gain = 1'b0;
        rx_bias_out.mixer_boost      = s_reg.rx_ctrl1[9];
      end
      GAIN_MED: begin
        rx_bias_out.amp_reduced_gain = s_reg.rx_ctrl1[10];
        rx_bias_out.mixer_boost      = s_reg.rx_ctrl1[8];
      end
      default: begin
        rx_bias_out.amp_reduced_gain = s_reg.rx_ctrl1[11];
        rx_bias_out.mixer_boost      = 1'b0;
      end
    endcase
    rx_bias_out.bandpass_bias_reduce       = s_reg.rx_ctrl1[13];
    rx_bias_out.bandpass_bias_mid_select   = s_reg.rx_ctrl1[12];
    rx_bias_out.amp_varactor_select        = s_reg.rx_ctrl1[7:6];
    rx_bias_out.rx_mixer_output_current    = s_reg.rx_ctrl1[5:4];
    rx_bias_out.rx_mixer_common_mode_level = s_reg.rx_ctrl1[3:2];
    rx_bias_out.rx_mixer_current_select    = s_reg.rx_ctrl1[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_cmd_idle;
    start_transmit_command_in && s_reg.tx_state != TX_WAIT;
  endsequence

  property p_turn_start;
    @(posedge clock_in) disable iff (!rst_n)
      s_cmd_idle |=> tx_waiting_out && !tx_enable_out;
  endproperty
  a_turn_start: assert property (p_turn_start)
    else $error("turnaround wait not entered");

  property p_turn_end;
    @(posedge clock_in) disable iff (!rst_n)
      (tx_waiting_out && s_reg.turn_cnt == '0) |=> tx_enable_out;
  endproperty
  a_turn_end: assert property (p_turn_end)
    else $error("transmit not started after wait");

  property p_bit5;
    @(posedge clock_in) disable iff (!rst_n)
      s_reg.tx_ctrl[5];
  endproperty
  a_bit5: assert property (p_bit5)
    else $error("tx reserved bit lost");

  property p_rx_res;
    @(posedge clock_in) disable iff (!rst_n)
      s_reg.rx_ctrl0[15:14] == 2'h0 && s_reg.rx_ctrl1[15:14] == 2'h0;
  endproperty
  a_rx_res: assert property (p_rx_res)
    else $error("rx reserved bits set");

  property p_tx_write;
    @(posedge clock_in) disable iff (!rst_n)
      (reg_write_in && reg_addr_in == TX_CTRL_ADDR) |=>
        tx_bias_out.output_power_level == $past(reg_wdata_in[4:0]) &&
        tx_bias_out.tx_mixer_buffer_bias == $past(reg_wdata_in[15:14]);
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("tx write not applied");

  property p_pa_cur;
    @(posedge clock_in) disable iff (!rst_n)
      (reg_write_in && reg_addr_in == TX_CTRL_ADDR) |=>
        tx_bias_out.power_amp_current_adjust == $past(reg_wdata_in[8:6]);
  endproperty
  a_pa_cur: assert property (p_pa_cur)
    else $error("power_amp_current_adjust not applied");

  property p_comp_sel;
    @(posedge clock_in) disable iff (!rst_n)
      agc_step_in == GAIN_LOW |->
        rx_bias_out.amp_comp_current == s_reg.rx_ctrl0[7:6] &&
        rx_bias_out.amp_main_current == s_reg.rx_ctrl0[1:0];
  endproperty
  a_comp_sel: assert property (p_comp_sel)
    else $error("wrong gain step fields");

  property p_read;
    @(posedge clock_in) disable iff (!rst_n)
      (reg_read_in && reg_addr_in == RX_CTRL1_ADDR && !reg_write_in) |=>
        reg_rdata_out == $past(s_reg.rx_ctrl1);
  endproperty
  a_read: assert property (p_read)
    else $error("read data mismatch");

  sequence s_wait_run;
    tx_waiting_out && s_reg.turn_cnt != '0;
  endsequence

  property p_turn_load;
    @(posedge clock_in) disable iff (!rst_n)
      s_cmd_idle |=> s_reg.turn_cnt ==
        ($past(s_reg.tx_ctrl[TX_DELAY_BIT]) ? TURN_CNT_W'(LONG_CYC - 1)
                                            : TURN_CNT_W'(SHORT_CYC - 1));
  endproperty
  a_turn_load: assert property (p_turn_load)
    else $error("turnaround count not loaded");

  property p_turn_step;
    @(posedge clock_in) disable iff (!rst_n)
      s_wait_run |=> tx_waiting_out &&
        s_reg.turn_cnt == $past(s_reg.turn_cnt) - 1'b1;
  endproperty
  a_turn_step: assert property (p_turn_step)
    else $error("turnaround count did not step");

  property p_tx_fields;
    @(posedge clock_in) disable iff (!rst_n)
      (reg_write_in && reg_addr_in == TX_CTRL_ADDR) |=>
        tx_bias_out.tx_mixer_varactor_select == $past(reg_wdata_in[12:11]) &&
        tx_bias_out.tx_mixer_current_select == $past(reg_wdata_in[10:9]);
  endproperty
  a_tx_fields: assert property (p_tx_fields)
    else $error("tx mixer fields not applied");

  property p_rx0_write;
    @(posedge clock_in) disable iff (!rst_n)
      (reg_write_in && reg_addr_in == RX_CTRL0_ADDR) |=>
        rx_bias_out.rx_mixer_buffer_bias == $past(reg_wdata_in[13:12]);
  endproperty
  a_rx0_write: assert property (p_rx0_write)
    else $error("rx mixer buffer bias not applied");

  property p_top_step;
    @(posedge clock_in) disable iff (!rst_n)
      agc_step_in == GAIN_HIGH |->
        rx_bias_out.amp_comp_current == s_reg.rx_ctrl0[11:10] &&
        rx_bias_out.amp_main_current == s_reg.rx_ctrl0[5:4];
  endproperty
  a_top_step: assert property (p_top_step)
    else $error("top step amp currents wrong");

  property p_gain_top;
    @(posedge clock_in) disable iff (!rst_n)
      agc_step_in == GAIN_HIGH |->
        rx_bias_out.mixer_boost == s_reg.rx_ctrl1[9] &&
        !rx_bias_out.amp_reduced_gain;
  endproperty
  a_gain_top: assert property (p_gain_top)
    else $error("top step gain enables wrong");

  property p_gain_mid;
    @(posedge clock_in) disable iff (!rst_n)
      agc_step_in == GAIN_MED |->
        rx_bias_out.amp_reduced_gain == s_reg.rx_ctrl1[10] &&
        rx_bias_out.mixer_boost == s_reg.rx_ctrl1[8];
  endproperty
  a_gain_mid: assert property (p_gain_mid)
    else $error("mid step gain enables wrong");

  property p_gain_low;
    @(posedge clock_in) disable iff (!rst_n)
      agc_step_in == GAIN_LOW |->
        rx_bias_out.amp_reduced_gain == s_reg.rx_ctrl1[11] &&
        !rx_bias_out.mixer_boost;
  endproperty
  a_gain_low: assert property (p_gain_low)
    else $error("bottom step gain enables wrong");

  property p_rx1_write;
    @(posedge clock_in) disable iff (!rst_n)
      (reg_write_in && reg_addr_in == RX_CTRL1_ADDR) |=>
        rx_bias_out.amp_varactor_select == $past(reg_wdata_in[7:6]) &&
        rx_bias_out.rx_mixer_output_current == $past(reg_wdata_in[5:4]);
  endproperty
  a_rx1_write: assert property (p_rx1_write)
    else $error("rx control one fields not applied");

  property p_rdata_idle;
    @(posedge clock_in) disable iff (!rst_n)
      !reg_read_in |=> reg_rdata_out == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared");

  // fields must hold between writes, the analog side sees them directly
  property p_hold;
    @(posedge clock_in) disable iff (!rst_n)
      !reg_write_in |=> $stable(s_reg.tx_ctrl) &&
        $stable(s_reg.rx_ctrl0) && $stable(s_reg.rx_ctrl1);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without a write");

endmodule : rfbc_regs

// [logic/rfbc_pkg.sv]
// package of register map, field layout, reset values and timing for rfbc
package rfbc_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  localparam logic [5:0] TX_CTRL_ADDR  = 6'h15;
  localparam logic [5:0] RX_CTRL0_ADDR = 6'h16;
  localparam logic [5:0] RX_CTRL1_ADDR = 6'h17;

  localparam logic [15:0] TX_CTRL_RESET  = 16'hA0FF;
  localparam logic [15:0] RX_CTRL0_RESET = 16'h12E5;
  localparam logic [15:0] RX_CTRL1_RESET = 16'h0A56;

  // reserved bit masks: tx bit 5 reads back one, rx 15:14 read zero
  localparam logic [15:0] TX_CTRL_FIXED1 = 16'h0020;
  localparam logic [15:0] RX_CTRL_MASK   = 16'h3FFF;

  localparam int unsigned TX_BUF_MSB   = 15;
  localparam int unsigned TX_DELAY_BIT = 13;

  // turnaround times, clock rate and counter width
  localparam int unsigned CLK_MHZ          = 40;
  localparam int unsigned TURN_SHORT_US    = 128;
  localparam int unsigned TURN_LONG_US     = 192;
  localparam int unsigned TURN_SHORT_CYC   = TURN_SHORT_US * CLK_MHZ;
  localparam int unsigned TURN_LONG_CYC    = TURN_LONG_US * CLK_MHZ;
  localparam int unsigned TURN_CNT_W       = 13;

  typedef enum logic [1:0] {
    GAIN_HIGH,
    GAIN_MED,
    GAIN_LOW
  } rfbc_gain_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_WAIT,
    TX_ON
  } rfbc_txst_t;

  typedef struct packed {
    logic [1:0] tx_mixer_buffer_bias;
    logic [1:0] tx_mixer_varactor_select;
    logic [1:0] tx_mixer_current_select;
    logic [2:0] power_amp_current_adjust;
    logic [4:0] output_power_level;
  } rfbc_tx_bias_t;

  typedef struct packed {
    logic [1:0] rx_mixer_buffer_bias;
    logic [1:0] amp_comp_current;
    logic [1:0] amp_main_current;
    logic       amp_reduced_gain;
    logic       mixer_boost;
    logic       bandpass_bias_reduce;
    logic       bandpass_bias_mid_select;
    logic [1:0] amp_varactor_select;
    logic [1:0] rx_mixer_output_current;
    logic [1:0] rx_mixer_common_mode_level;
    logic [1:0] rx_mixer_current_select;
  } rfbc_rx_bias_t;

  typedef struct packed {
    logic [15:0]            tx_ctrl;
    logic [15:0]            rx_ctrl0;
    logic [15:0]            rx_ctrl1;
    rfbc_txst_t             tx_state;
    logic [TURN_CNT_W-1:0]  turn_cnt;
    logic [15:0]            rdata;
  } rfbc_state_t;

endpackage : rfbc_pkg

// [tb/test_rf_tx_rx_bias_control_regs.sv]
// self-checking bench for the bias control register bank
`timescale 1ns/1ps

module test_rf_tx_rx_bias_control_regs;
  import rfbc_pkg::*;

  // short turnaround counts keep the run brief
  localparam int unsigned SHORT = 4;
  localparam int unsigned LONG  = 6;

  logic          clock_in                  = 1'b0;
  logic          resetn_in                 = 1'b0;
  logic [5:0]    reg_addr_in               = 6'h00;
  logic          reg_write_in              = 1'b0;
  logic          reg_read_in               = 1'b0;
  logic [15:0]   reg_wdata_in              = 16'h0000;
  logic          start_transmit_command_in = 1'b0;
  rfbc_gain_t    agc_step_in               = GAIN_HIGH;
  logic [15:0]   reg_rdata_out;
  logic          tx_enable_out;
  logic          tx_waiting_out;
  rfbc_tx_bias_t tx_bias_out;
  rfbc_rx_bias_t rx_bias_out;
  logic [15:0]   exp_q[$];
  logic          rd_seen                   = 1'b0;
  int            failures                  = 0;
  int            compares                  = 0;
  logic [15:0]   t, r0, r1;

  rfbc_regs #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (
    .clock_in                  (clock_in),
    .resetn_in                 (resetn_in),
    .reg_addr_in               (reg_addr_in),
    .reg_write_in              (reg_write_in),
    .reg_read_in               (reg_read_in),
    .reg_wdata_in              (reg_wdata_in),
    .start_transmit_command_in (start_transmit_command_in),
    .agc_step_in               (agc_step_in),
    .reg_rdata_out             (reg_rdata_out),
    .tx_enable_out             (tx_enable_out),
    .tx_waiting_out            (tx_waiting_out),
    .tx_bias_out               (tx_bias_out),
    .rx_bias_out               (rx_bias_out)
  );

  always #12.5 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic cmp_rd(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_rd

  task automatic cmp_vec(string nm, logic [17:0] e, logic [17:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_vec

  // read data shows one cycle after the strobe is taken
  always @(posedge clock_in) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("Error read_data expected none seen %h", reg_rdata_out);
      end else
        cmp_rd("read_data", exp_q.pop_front(), reg_rdata_out);
    end
    rd_seen <= reg_read_in;
  end

  initial begin
    repeat (5000) @(posedge clock_in);
    failures++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic rfbc_tx_bias_t tx_exp(logic [15:0] d);
    return {d[15:14], d[12:11], d[10:9], d[8:6], d[4:0]};
  endfunction : tx_exp

  function automatic rfbc_rx_bias_t rx_exp(logic [15:0] a, logic [15:0] b,
                                           logic [1:0] s);
    logic [1:0] c;
    logic [1:0] m;
    logic       g;
    logic       h;
    c = (s == 2'd0) ? a[11:10] : (s == 2'd1) ? a[9:8] : a[7:6];
    m = (s == 2'd0) ? a[5:4] : (s == 2'd1) ? a[3:2] : a[1:0];
    g = (s == 2'd0) ? 1'b0 : (s == 2'd1) ? b[10] : b[11];
    h = (s == 2'd0) ? b[9] : (s == 2'd1) ? b[8] : 1'b0;
    return {a[13:12], c, m, g, h, b[13:12], b[7:6], b[5:4], b[3:2], b[1:0]};
  endfunction : rx_exp

  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(logic [5:0] a, logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
  endtask : rd

  task automatic do_reset();
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
  endtask : do_reset

  // readback, tx outputs and every agc step of the rx outputs
  task automatic check_all(logic [15:0] a, logic [15:0] b, logic [15:0] c);
    rd(TX_CTRL_ADDR, a);
    rd(RX_CTRL0_ADDR, b);
    rd(RX_CTRL1_ADDR, c);
    #1;
    cmp_vec("tx_bias", 18'(tx_exp(a)), 18'(tx_bias_out));
    for (int s = 0; s < 4; s++) begin
      @(posedge clock_in);
      agc_step_in <= rfbc_gain_t'(s[1:0]);
      #1;
      cmp_vec("rx_bias", rx_exp(b, c, s[1:0]), rx_bias_out);
    end
  endtask : check_all

  // second command during the wait must not stretch it
  task automatic turn(logic sel, int unsigned want, logic again);
    int n;
    n = 0;
    wr(TX_CTRL_ADDR, {2'd2, sel, 2'd0, 2'd0, 3'd3, 1'b1, 5'd31});
    @(posedge clock_in);
    start_transmit_command_in <= 1'b1;
    @(posedge clock_in);
    start_transmit_command_in <= 1'b0;
    #1;
    cmp_vec("tx_waiting", 18'(1), 18'(tx_waiting_out));
    while (tx_enable_out !== 1'b1 && n < 50) begin
      @(posedge clock_in);
      n++;
      start_transmit_command_in <= again && n == 2;
      #1;
    end
    cmp_vec("turnaround", 18'(want), 18'(n));
  endtask : turn

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hA1AC9BA2));
    do_reset();
    t  = {2'd2, 1'b1, 2'd0, 2'd0, 3'd3, 1'b1, 5'd31};
    r0 = {2'd0, 2'd1, 2'd0, 2'd2, 2'd3, 2'd2, 2'd1, 2'd1};
    r1 = {2'd0, 4'b0010, 2'b10, 2'd1, 2'd1, 2'd1, 2'd2};
    check_all(t, r0, r1);
    repeat (4) begin
      t      = 16'($urandom());
      t[5]   = 1'b1;
      r0     = 16'($urandom()) & 16'h3FFF;
      r1     = 16'($urandom()) & 16'h3FFF;
      wr(TX_CTRL_ADDR, t);
      wr(RX_CTRL0_ADDR, r0);
      wr(RX_CTRL1_ADDR, r1);
      wr(6'h18, 16'($urandom()));
      wr(6'h14, 16'($urandom()));
      check_all(t, r0, r1);
      rd(6'h18, 16'h0000);
      rd(6'h00, 16'h0000);
    end
    turn(1'b1, LONG, 1'b0);
    turn(1'b0, SHORT, 1'b1);
    turn(1'b1, LONG, 1'b0);
    do_reset();
    cmp_vec("tx_enable", 18'(0), 18'(tx_enable_out));
    t  = {2'd2, 1'b1, 2'd0, 2'd0, 3'd3, 1'b1, 5'd31};
    r0 = {2'd0, 2'd1, 2'd0, 2'd2, 2'd3, 2'd2, 2'd1, 2'd1};
    r1 = {2'd0, 4'b0010, 2'b10, 2'd1, 2'd1, 2'd1, 2'd2};
    check_all(t, r0, r1);
    repeat (4) @(posedge clock_in);
    test_done();
  end

endmodule : test_rf_tx_rx_bias_control_regs
